// ===== alu_unit_defines.svh
// Constants for the divide, increment/decrement and AND execution unit
// Notes on behaviour
// - Single divide: quotient to dest, remainder next
// - Single divide operands are unsigned 16-bit
// - Zero divisor: no execution, output off, error
// - Error flag sticky until program clears it
// - Index destination keeps quotient, drops remainder, except on double divide quotient overflow
// - Double divide: 32-bit dividend by 16-bit divisor
// - Quotient overflow: max quotient, zero remainder, error
// - Divides treat all data as unsigned
// - Increment adds one, writes back same word
// - Increment wraps, no saturation
// - Decrement subtracts one, writes back same word
// - Decrement wraps, no saturation
// - AND combines sources bitwise into destination
`ifndef ALU_UNIT_DEFINES_SVH
`define ALU_UNIT_DEFINES_SVH
`define WORD_W        16
`define DBL_W         32
`define QUOT_MAX      16'hFFFF
`define WORD_ZERO     16'h0000
`define WORD_ONE      16'h0001
`define DIV_STEPS     6'h20
`define STEP_ZERO     6'h00
`define STEP_ONE      6'h01
`endif

// ===== alu_unit_pkg.sv
// Types for the execution unit
package alu_unit_pkg;
  typedef enum logic [2:0] {
    OP_UDIV = 3'h0,
    OP_DDIV = 3'h1,
    OP_INC  = 3'h2,
    OP_DEC  = 3'h3,
    OP_AND  = 3'h4
  } alu_op_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_DIV  = 2'h1,
    ST_DONE = 2'h2
  } alu_state_t;
endpackage : alu_unit_pkg

// ===== restoring_divider.sv
// Sequential unsigned restoring divider, 32-bit dividend by 16-bit divisor
`timescale 1ns/10ps
`default_nettype none
`include "alu_unit_defines.svh"
module restoring_divider (
  input  wire logic                ref_clk_i,
  input  wire logic                rst_i,
  input  wire logic                start_i,
  input  wire logic [`DBL_W-1:0]   dividend_i,
  input  wire logic [`WORD_W-1:0]  divisor_i,
  output logic                     busy_o,
  output logic [`DBL_W-1:0]        quot_o,
  output logic [`WORD_W-1:0]       rem_o
);
  logic [`DBL_W-1:0]   quot_r,  quot_nxt;
  logic [`WORD_W:0]    rem_r,   rem_nxt;
  logic [`WORD_W-1:0]  dvs_r,   dvs_nxt;
  logic [5:0]          cnt_r,   cnt_nxt;
  logic [`WORD_W:0]    trial;

  // One quotient bit per cycle, unsigned throughout
  always_comb begin
    quot_nxt = quot_r;
    rem_nxt  = rem_r;
    dvs_nxt  = dvs_r;
    cnt_nxt  = cnt_r;
    trial    = {rem_r[`WORD_W-1:0], quot_r[`DBL_W-1]};
    if (start_i && cnt_r == `STEP_ZERO) begin
      quot_nxt = dividend_i;
      rem_nxt  = '0;
      dvs_nxt  = divisor_i;
      cnt_nxt  = `DIV_STEPS;
    end else if (cnt_r != `STEP_ZERO) begin
      if (trial >= {1'b0, dvs_r}) begin
        rem_nxt  = trial - {1'b0, dvs_r};
        quot_nxt = {quot_r[`DBL_W-2:0], 1'b1};
      end else begin
        rem_nxt  = trial;
        quot_nxt = {quot_r[`DBL_W-2:0], 1'b0};
      end
      cnt_nxt = cnt_r - `STEP_ONE;
    end
  end

  // State registers
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      quot_r <= '0;
      rem_r  <= '0;
      dvs_r  <= '0;
      cnt_r  <= `STEP_ZERO;
    end else begin
      quot_r <= quot_nxt;
      rem_r  <= rem_nxt;
      dvs_r  <= dvs_nxt;
      cnt_r  <= cnt_nxt;
    end
  end

  assign busy_o = (cnt_r != `STEP_ZERO);
  assign quot_o = quot_r;
  assign rem_o  = rem_r[`WORD_W-1:0];
endmodule : restoring_divider
`default_nettype wire

// ===== alu_unit.sv
// Execution unit: unsigned divides, increment, decrement and bitwise AND
`timescale 1ns/10ps
`default_nettype none
`include "alu_unit_defines.svh"
module alu_unit
  import alu_unit_pkg::*;
(
  input  wire logic                ref_clk_i,
  input  wire logic                rst_i,
  input  wire logic                enable_i,
  input  wire alu_op_t             op_i,
  input  wire logic [`WORD_W-1:0]  src_a_i,
  input  wire logic [`WORD_W-1:0]  src_a_hi_i,
  input  wire logic [`WORD_W-1:0]  src_b_i,
  input  wire logic                dest_is_index_i,
  input  wire logic                error_clear_i,
  output logic                     done_o,
  output logic                     output_on_o,
  output logic                     wr_lo_o,
  output logic [`WORD_W-1:0]       res_lo_o,
  output logic                     wr_hi_o,
  output logic [`WORD_W-1:0]       res_hi_o,
  output logic                     instruction_error_flag_o
);
  alu_state_t          state_r,  state_nxt;
  logic                done_r,   done_nxt;
  logic                out_r,    out_nxt;
  logic                wlo_r,    wlo_nxt;
  logic                whi_r,    whi_nxt;
  logic [`WORD_W-1:0]  lo_r,     lo_nxt;
  logic [`WORD_W-1:0]  hi_r,     hi_nxt;
  logic                err_r,    err_nxt;
  logic                dbl_r,    dbl_nxt;
  logic                idx_r,    idx_nxt;
  logic                div_start;
  logic                div_busy;
  logic [`DBL_W-1:0]   div_quot;
  logic [`WORD_W-1:0]  div_rem;
  logic [`DBL_W-1:0]   div_dividend;
  logic                err_set;

  // Dividend: double width joins high and low words
  assign div_dividend = (op_i == OP_DDIV) ? {src_a_hi_i, src_a_i}
                                          : {`WORD_ZERO, src_a_i};

  restoring_divider u_div (
    .ref_clk_i  (ref_clk_i),
    .rst_i      (rst_i),
    .start_i    (div_start),
    .dividend_i (div_dividend),
    .divisor_i  (src_b_i),
    .busy_o     (div_busy),
    .quot_o     (div_quot),
    .rem_o      (div_rem)
  );

  // Sequencer and result formation
  always_comb begin
    state_nxt = state_r;
    done_nxt  = 1'b0;
    out_nxt   = 1'b0;
    wlo_nxt   = 1'b0;
    whi_nxt   = 1'b0;
    lo_nxt    = lo_r;
    hi_nxt    = hi_r;
    dbl_nxt   = dbl_r;
    idx_nxt   = idx_r;
    div_start = 1'b0;
    err_set   = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (enable_i) begin
          case (op_i)
            OP_UDIV, OP_DDIV: begin
              if (src_b_i == `WORD_ZERO) begin
                done_nxt = 1'b1;
                err_set  = 1'b1;
              end else begin
                div_start = 1'b1;
                dbl_nxt   = (op_i == OP_DDIV);
                idx_nxt   = dest_is_index_i;
                state_nxt = ST_DIV;
              end
            end
            OP_INC: begin
              lo_nxt   = src_a_i + `WORD_ONE;
              wlo_nxt  = 1'b1;
              out_nxt  = 1'b1;
              done_nxt = 1'b1;
            end
            OP_DEC: begin
              lo_nxt   = src_a_i - `WORD_ONE;
              wlo_nxt  = 1'b1;
              out_nxt  = 1'b1;
              done_nxt = 1'b1;
            end
            OP_AND: begin
              lo_nxt   = src_a_i & src_b_i;
              wlo_nxt  = 1'b1;
              out_nxt  = 1'b1;
              done_nxt = 1'b1;
            end
            default: begin
              done_nxt = 1'b1;
            end
          endcase
        end
      end
      ST_DIV: begin
        if (!div_busy) begin
          state_nxt = ST_DONE;
        end
      end
      ST_DONE: begin
        out_nxt   = 1'b1;
        done_nxt  = 1'b1;
        wlo_nxt   = 1'b1;
        state_nxt = ST_IDLE;
        if (dbl_r && div_quot[`DBL_W-1:`WORD_W] != `WORD_ZERO) begin
          lo_nxt  = `QUOT_MAX;
          hi_nxt  = `WORD_ZERO;
          whi_nxt = 1'b1;
          err_set = 1'b1;
        end else begin
          lo_nxt  = div_quot[`WORD_W-1:0];
          hi_nxt  = div_rem;
          whi_nxt = !idx_r;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    // Sticky error: set wins over program clear
    err_nxt = err_set ? 1'b1 : (error_clear_i ? 1'b0 : err_r);
  end

  // State registers
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
      done_r  <= 1'b0;
      out_r   <= 1'b0;
      wlo_r   <= 1'b0;
      whi_r   <= 1'b0;
      lo_r    <= `WORD_ZERO;
      hi_r    <= `WORD_ZERO;
      err_r   <= 1'b0;
      dbl_r   <= 1'b0;
      idx_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      done_r  <= done_nxt;
      out_r   <= out_nxt;
      wlo_r   <= wlo_nxt;
      whi_r   <= whi_nxt;
      lo_r    <= lo_nxt;
      hi_r    <= hi_nxt;
      err_r   <= err_nxt;
      dbl_r   <= dbl_nxt;
      idx_r   <= idx_nxt;
    end
  end

  assign done_o                   = done_r;
  assign output_on_o              = out_r;
  assign wr_lo_o                  = wlo_r;
  assign wr_hi_o                  = whi_r;
  assign res_lo_o                 = lo_r;
  assign res_hi_o                 = hi_r;
  assign instruction_error_flag_o = err_r;

  // Checks
  sequence s_zero_div;
    state_r == ST_IDLE && enable_i && (op_i == OP_UDIV || op_i == OP_DDIV)
      && src_b_i == `WORD_ZERO;
  endsequence

  a_zero_div_block: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    s_zero_div |=> done_o && !output_on_o && !wr_lo_o && instruction_error_flag_o)
    else $error("zero divisor not refused");

  a_inc_wraps: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    state_r == ST_IDLE && enable_i && op_i == OP_INC
      |=> res_lo_o == $past(src_a_i) + 16'h0001 && output_on_o)
    else $error("increment result wrong");

  a_dec_wraps: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    state_r == ST_IDLE && enable_i && op_i == OP_DEC
      |=> res_lo_o == $past(src_a_i) - 16'h0001 && wr_lo_o)
    else $error("decrement result wrong");

  a_and_result: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    state_r == ST_IDLE && enable_i && op_i == OP_AND
      |=> res_lo_o == ($past(src_a_i) & $past(src_b_i)))
    else $error("and result wrong");

  a_idle_quiet: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    state_r == ST_IDLE && !enable_i |=> !output_on_o && !wr_lo_o && !wr_hi_o)
    else $error("disabled unit acted");

  a_err_sticky: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    instruction_error_flag_o && !error_clear_i |=> instruction_error_flag_o)
    else $error("error flag dropped");

  a_div_finishes: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    state_r == ST_IDLE && enable_i && op_i == OP_UDIV && src_b_i != `WORD_ZERO
      |=> ##[33:35] done_o && output_on_o)
    else $error("divide did not finish");

  // Operands were taken 34 edges before the done state is sampled
  a_div_math: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    state_r == ST_DONE && !(dbl_r && div_quot[31:16] != 16'h0000)
      |-> div_quot * {16'h0000, $past(src_b_i, 34)} + {16'h0000, div_rem}
            == $past(div_dividend, 34)
          && div_rem < $past(src_b_i, 34))
    else $error("divide math wrong");

  a_ovf_sat: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    state_r == ST_DONE && dbl_r && div_quot[31:16] != 16'h0000
      |=> res_lo_o == 16'hFFFF && res_hi_o == 16'h0000 && output_on_o
          && instruction_error_flag_o)
    else $error("overflow not saturated");

  a_index_drop: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    state_r == ST_DONE && idx_r && !dbl_r |=> wr_lo_o && !wr_hi_o)
    else $error("remainder written to index");
endmodule : alu_unit
`default_nettype wire

// ===== reg_file_model.sv
// Register file model that takes the unit's result writes
`timescale 1ns/10ps
`default_nettype none
module reg_file_model (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic        wr_lo_i,
  input  wire logic [15:0] res_lo_i,
  input  wire logic        wr_hi_i,
  input  wire logic [15:0] res_hi_i,
  output logic [15:0]      dest_word_o,
  output logic [15:0]      next_word_o
);
  // Words C and C+1; a marker value shows a word never written
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      dest_word_o <= 16'hA5A5;
      next_word_o <= 16'hA5A5;
    end else begin
      if (wr_lo_i) begin
        dest_word_o <= res_lo_i;
      end
      if (wr_hi_i) begin
        next_word_o <= res_hi_i;
      end
    end
  end
endmodule : reg_file_model
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench for the execution unit
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) chk(n, e, g)
module tb_top import alu_unit_pkg::*;;
  logic        ref_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        enable_i = 1'b0;
  alu_op_t     op_i = OP_INC;
  logic [15:0] src_a_i = 16'h0000;
  logic [15:0] src_a_hi_i = 16'h0000;
  logic [15:0] src_b_i = 16'h0000;
  logic        dest_is_index_i = 1'b0;
  logic        error_clear_i = 1'b0;
  logic        done_o, output_on_o, wr_lo_o, wr_hi_o, err_o;
  logic [15:0] res_lo_o, res_hi_o, dest_w, next_w;
  logic [35:0] exp_q[$];
  logic [35:0] exp_v, got_v;
  logic        err_exp = 1'b0;
  logic [31:0] rnd = 32'h13B7;
  int          n_fail = 0;
  int          samples_checked = 0;

  alu_unit i_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .enable_i(enable_i), .op_i(op_i),
    .src_a_i(src_a_i), .src_a_hi_i(src_a_hi_i), .src_b_i(src_b_i),
    .dest_is_index_i(dest_is_index_i), .error_clear_i(error_clear_i), .done_o(done_o),
    .output_on_o(output_on_o), .wr_lo_o(wr_lo_o), .res_lo_o(res_lo_o), .wr_hi_o(wr_hi_o),
    .res_hi_o(res_hi_o), .instruction_error_flag_o(err_o));
  reg_file_model i_regs (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .wr_lo_i(wr_lo_o),
    .res_lo_i(res_lo_o), .wr_hi_i(wr_hi_o), .res_hi_i(res_hi_o), .dest_word_o(dest_w),
    .next_word_o(next_w));

  // Clock and random source
  always #20 ref_clk_i = ~ref_clk_i;
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  // Drive one instruction at the falling edge and note what it should give
  task automatic run(alu_op_t op, logic [15:0] a, logic [15:0] h, logic [15:0] b, logic x);
    logic [31:0] dd;
    logic [31:0] qq;
    logic [31:0] rr;
    logic [35:0] ev;
    int          n;
    dd = (op == OP_UDIV) ? {16'h0000, a} : {h, a};
    case (op)
      OP_INC: ev = {4'hE, a + 16'h0001, 16'h0000};
      OP_DEC: ev = {4'hE, a - 16'h0001, 16'h0000};
      OP_AND: ev = {4'hE, a & b, 16'h0000};
      default: begin
        qq = dd / {16'h0000, b};
        rr = dd % {16'h0000, b};
        if (b == 16'h0000) begin
          ev = {4'h8, 32'h0000_0000};
          err_exp = 1'b1;
        end else if (qq > 32'h0000_FFFF) begin
          ev = {4'hF, 16'hFFFF, 16'h0000};
          err_exp = 1'b1;
        end else begin
          ev = {3'h7, ~x, qq[15:0], rr[15:0]};
        end
      end
    endcase
    exp_q.push_back(ev);
    op_i = op;
    src_a_i = a;
    src_a_hi_i = h;
    src_b_i = b;
    dest_is_index_i = x;
    enable_i = 1'b1;
    @(negedge ref_clk_i);
    enable_i = 1'b0;
    n = 0;
    while (done_o !== 1'b1 && n < 40) begin
      @(negedge ref_clk_i);
      n++;
    end
    if (n == 40) n_fail++;
    @(negedge ref_clk_i);
    `CHK("err_flag", {15'h0000, err_exp}, {15'h0000, err_o});
  endtask : run

  task automatic clr;
    error_clear_i = 1'b1;
    @(negedge ref_clk_i);
    error_clear_i = 1'b0;
    err_exp = 1'b0;
    @(negedge ref_clk_i);
    `CHK("err_clear", 16'h0000, {15'h0000, err_o});
  endtask : clr

  // Monitor: any result pulse takes the oldest note
  always @(posedge ref_clk_i) begin
    #1;
    if ({done_o, output_on_o, wr_lo_o, wr_hi_o} !== 4'h0) begin
      got_v = {done_o, output_on_o, wr_lo_o, wr_hi_o, res_lo_o, res_hi_o};
      exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 36'h0;
      `CHK("flags", {12'h000, exp_v[35:32]}, {12'h000, got_v[35:32]});
      if (exp_v[33]) `CHK("res_lo", exp_v[31:16], got_v[31:16]);
      if (exp_v[32]) `CHK("res_hi", exp_v[15:0], got_v[15:0]);
    end
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    n_fail++;
    print_verdict();
  end

  // Main sequence
  initial begin
    repeat (2) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    rst_i = 1'b0;
    repeat (3) @(negedge ref_clk_i);
    `CHK("err_reset", 16'h0000, {15'h0000, err_o});
    run(OP_INC, 16'h7FFF, 16'h0000, 16'h0000, 1'b0);
    run(OP_INC, 16'hFFFF, 16'h0000, 16'h0000, 1'b0);
    run(OP_DEC, 16'h8000, 16'h0000, 16'h0000, 1'b0);
    run(OP_DEC, 16'h0000, 16'h0000, 16'h0000, 1'b0);
    run(OP_AND, 16'h3456, 16'h0000, 16'hFF00, 1'b0);
    run(OP_UDIV, 16'hD431, 16'h0000, 16'h012C, 1'b0);
    run(OP_UDIV, 16'h03E8, 16'h0000, 16'h0007, 1'b1);
    `CHK("dest_word", 16'h008E, dest_w);
    `CHK("next_word", 16'h0015, next_w);
    run(OP_UDIV, 16'hFFFF, 16'h0000, 16'hFFFE, 1'b0);
    run(OP_UDIV, 16'h0005, 16'h0000, 16'h0000, 1'b0);
    run(OP_INC, 16'h1234, 16'h0000, 16'h0000, 1'b0);
    clr();
    run(OP_DDIV, 16'h11E1, 16'h0005, 16'h0FA0, 1'b0);
    run(OP_DDIV, 16'h0001, 16'hFFFE, 16'hFFFF, 1'b0);
    run(OP_DDIV, 16'hFFFF, 16'hFFFF, 16'hFFFF, 1'b1);
    clr();
    run(OP_DDIV, 16'h0001, 16'h0001, 16'h0000, 1'b0);
    clr();
    for (int i = 0; i < 16; i++) begin
      rnd = lfsr(rnd);
      run(alu_op_t'(3'(rnd % 5)), rnd[15:0], {8'h00, rnd[31:24]}, rnd[31:16], rnd[5]);
    end
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
